/* linked_list_dma_channels_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the list-driven DMA block.
module linked_list_dma_channels_test;
  import lld_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] pstrb, lat;
  logic [7:0] dreq, dack, pdata_in, pdata_out;
  lld_mem_req_t mem_req;
  lld_mem_rsp_t mem_rsp;
  int err_total, cmp_count, cyc;
  logic [15:0] got [$];

  lld_dma #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .dreq(dreq), .dack(dack), .pdata_in(pdata_in),
    .pdata_out(pdata_out), .irq(irq));
  lld_mem_model u_mem (.pclk(pclk), .presetn(presetn), .req(mem_req), .rsp(mem_rsp),
    .lat(lat));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Items acknowledged to peripherals in either direction, with the channel acknowledged.
  always @(posedge pclk) begin
    cyc++;
    if (dack !== 8'h0) got.push_back({dack, pdata_out});
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    e    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never drives psel again in this time step.
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0, 4'h0); endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask
  // Lays one list entry into memory, low byte first.
  task automatic put8(input logic [11:0] a, input logic [63:0] v);
    for (int i = 0; i < 8; i++) u_mem.mem[a + i] = v[8*i +: 8];
  endtask
  // Starts a channel: low bytes first, then the top byte that launches it.
  task automatic start(input logic [11:0] a, input logic [7:0] lo);
    wr(a, {24'h0, lo}, 4'h3);
    wr(a, 32'h0, 4'h4);
  endtask
  task automatic wait_stop(input logic [11:0] a);
    for (int i = 0; i < 200; i++) begin
      rd(a);
      if (rd_v[LLD_CCS_RUN] === 1'b0) break;
    end
    chk(rd_v[LLD_CCS_RUN], 1'b0);
  endtask

  task automatic t_regs;
    rd(12'h01c); chk(rd_v, 32'h0);
    rd(12'h010); chk(rd_v, 32'h4);
    wr(12'h010, 32'hffffff, 4'h3);
    rd(12'h010); chk(rd_v, 32'hfffc);
    wr(12'h01c, 32'hff, 4'hf);
    rd(12'h01c); chk(rd_v, 32'h7);
    wr(12'h01c, 32'h0, 4'hf);
    rd(12'h014); chk(e, 1'b1);
    rd(12'h090); chk(e, 1'b1);
  endtask
  task automatic t_special;
    wr(12'h080, 32'h1, 4'hf);
    wr(12'h074, 32'hffffffff, 4'hf);
    rd(12'h074); chk(rd_v, 32'hffffff);
    wr(12'h078, 32'hffffffff, 4'hf);
    rd(12'h078); chk(rd_v, 32'hffff);
  endtask
  // Channel 2: one buffer of two bytes read out, a link, then the list end.
  task automatic t_list;
    got.delete();
    wr(12'h02c, 32'h4, 4'hf);
    start(12'h020, 8'h80);
    dreq <= 8'h04;
    wait_stop(12'h02c);
    dreq <= 8'h0;
    chk(got.size(), 2);
    chk(got[0], 16'h04a5);
    chk(got[1], 16'h045a);
    chk(u_mem.mem[12'h085], 8'h0);
    chk(rd_v[LLD_CCS_END], 1'b1);
    rd(12'h020); chk(rd_v, 32'h104);
    rd(12'h024); chk(rd_v, 32'h302);
    rd(12'h028); chk(rd_v, 32'h0);
    chk(irq, 1'b0);
    wr(12'h088, 32'h4, 4'hf);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    rd(12'h084); chk(rd_v, 32'h4);
    rd(12'h084); chk(rd_v, 32'h0);
    @(posedge pclk);
    chk(irq, 1'b0);
  endtask
  // Channel 5: peripheral to memory in burst mode against a slow memory, then an
  // empty buffer that is written back at once, then the list end.
  task automatic t_burst;
    got.delete();
    lat <= 4'h3;
    wr(12'h05c, 32'h3, 4'hf);
    start(12'h050, 8'h40);
    dreq <= 8'h20;
    wait_stop(12'h05c);
    dreq <= 8'h0;
    chk(got.size(), 3);
    for (int i = 0; i < 3; i++) begin
      chk(u_mem.mem[12'h380 + i], 8'h3c);
      chk(got[i], 16'h203c);
    end
    chk(u_mem.mem[12'h045], 8'h0);
    rd(12'h050);
    chk(rd_v, 32'h54);
    rd(12'h054);
    chk(rd_v, 32'h390);
    rd(12'h084); chk(rd_v, 32'h0);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pstrb = 4'h0; lat = 4'h0; dreq = 8'h0; pdata_in = 8'h3c;
    err_total = 0; cmp_count = 0; cyc = 0;
    foreach (u_mem.mem[i]) u_mem.mem[i] = 8'h0;
    put8(12'h080, 64'h0000020000000300);
    put8(12'h088, 64'h0000000100000100);
    put8(12'h100, 64'h0000000200000000);
    put8(12'h040, 64'h0000030000000380);
    put8(12'h048, 64'h0000000000000390);
    put8(12'h050, 64'h0000000200000000);
    u_mem.mem[12'h300] = 8'ha5;
    u_mem.mem[12'h301] = 8'h5a;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_special();
    t_list();
    t_burst();
    end_of_test();
  end
endmodule

bind lld_dma lld_dma_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .dreq(dreq), .dack(dack),
  .pdata_in(pdata_in), .pdata_out(pdata_out), .irq(irq));

/* lld_dma.sv */
`timescale 1ns/1ps

// Summary of operation
// - Eight independent channels, each with its own list, buffer and control registers.
// - List base 21 bits, buffer address 24, buffer length 16, control 8.
// - List pointer and control/status are read and written by software anytime.
// - Buffer address and length reachable only while special access mode is set.
// - At buffer completion the final length is written back into the list.
// - Writing the list pointer top byte starts the channel; software writes it last.
// - A link entry loads the new list base into the list pointer.
// - Low three list pointer bits ignore writes and read back as 100.
// - Buffer address loads from the entry address field at buffer start.
// - Each completed transfer adds one to the buffer address.
// - Buffer length loads from the entry length field at buffer start.
// - Each completed transfer subtracts one from the buffer length.
// - Control/status selects direction, burst, interrupt enable and reports status.
module lld_dma #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave.
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // System memory master.
  output lld_pkg::lld_mem_req_t           mem_req,
  input  wire lld_pkg::lld_mem_rsp_t      mem_rsp,
  // Peripheral request and acknowledge, one per channel.
  input  wire logic [lld_pkg::LLD_NCH-1:0] dreq,
  output logic [lld_pkg::LLD_NCH-1:0]     dack,
  input  wire logic [7:0]                 pdata_in,
  output logic [7:0]                      pdata_out,
  // Interrupt.
  output logic                            irq
);
  import lld_pkg::*;

  // The decode below uses address bits 7:2 and needs the upper bits to be zero.
  if (ADDR_W < 8) begin : g_chk
    $error("lld_dma: ADDR_W must be at least 8");
  end

  // All state is one packed record.  The engine fields (state, channel, byte index,
  // entry scratch) are shared, which is why only one channel moves data at a time;
  // the per-channel arrays are private to each channel.
  typedef struct packed {
    lld_state_t                         st;
    logic [2:0]                         cur;
    logic [2:0]                         idx;
    logic [LLD_NCH-1:0][LLD_LP_W-1:0]   lp;
    logic [LLD_NCH-1:0][LLD_BAR_W-1:0]  bar;
    logic [LLD_NCH-1:0][LLD_BLR_W-1:0]  buffer_count;
    logic [LLD_NCH-1:0][2:0]            ctl;
    logic [LLD_NCH-1:0]                 run;
    logic [LLD_NCH-1:0]                 hbuf;
    logic [7:0]                         ltype;
    // Entry address and length low byte, held until the length high byte completes the entry.
    logic [LLD_BAR_W-1:0]               eaddr;
    logic [7:0]                         elen;
    logic                               spec;
    logic [LLD_NCH-1:0]                 ist;
    logic [LLD_NCH-1:0]                 imsk;
    lld_mem_req_t                       mreq;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
    logic [LLD_NCH-1:0]                 dack;
    logic [7:0]                         pdata;
    logic                               irq;
  } lld_regs_t;

  lld_regs_t q_r;
  lld_regs_t q_nxt;

  logic                 acc;
  logic                 glob;
  logic                 hi_zero;
  logic [2:0]           rch;
  logic [1:0]           rsel;
  logic                 hit;
  logic [31:0]          rd;
  logic [LLD_NCH-1:0]   ev;
  logic [LLD_NCH-1:0]   clr;
  logic                 found;
  logic [2:0]           pick;
  logic [LLD_BLR_W-1:0] blr_dec;

  // Address decode and read mux; this is the same whether the access reads or writes.
  always_comb begin
    acc     = psel & penable;
    glob    = paddr[7];
    rch     = paddr[6:4];
    rsel    = paddr[3:2];
    hi_zero = (paddr >> 8) == '0;
    hit     = 1'b0;
    rd      = 32'h0000_0000;
    // Anything not matched here leaves hit low, so the access is refused with an error
    // and a zero word rather than landing on some alias of a real register.
    if (hi_zero && paddr[1:0] == 2'h0) begin
      if (glob) begin
        unique case (rsel)
          LLD_OFF_GCTL: begin
            hit = !paddr[6] && paddr[5:4] == 2'h0;
            rd  = {31'h0000_0000, q_r.spec};
          end
          LLD_OFF_IST: begin
            hit = !paddr[6] && paddr[5:4] == 2'h0;
            rd  = {24'h00_0000, q_r.ist};
          end
          LLD_OFF_IMSK: begin
            hit = !paddr[6] && paddr[5:4] == 2'h0;
            rd  = {24'h00_0000, q_r.imsk};
          end
          default: begin
            hit = 1'b0;
          end
        endcase
      end else begin
        unique case (rsel)
          LLD_OFF_LP: begin
            hit = 1'b1;
            rd  = {8'h00, q_r.lp[rch], LLD_LP_LOW};
          end
          LLD_OFF_BAR: begin
            hit = q_r.spec;
            rd  = {8'h00, q_r.bar[rch]};
          end
          LLD_OFF_BLR: begin
            hit = q_r.spec;
            rd  = {16'h0000, q_r.buffer_count[rch]};
          end
          LLD_OFF_CCS: begin
            hit = 1'b1;
            rd  = {26'h000_0000, q_r.ist[rch], q_r.hbuf[rch], q_r.run[rch],
                   q_r.ctl[rch]};
          end
        endcase
      end
    end
  end

  // Lowest numbered channel that wants service: one that is running and either has no
  // buffer loaded yet or has its peripheral requesting.  Fixed priority is fair enough
  // because channels without burst give the engine back after every item.
  always_comb begin
    found = 1'b0;
    pick  = 3'h0;
    for (int i = LLD_NCH - 1; i >= 0; i--) begin
      if (q_r.run[i] && (!q_r.hbuf[i] || (dreq[i] && !q_r.dack[i]))) begin
        found = 1'b1;
        pick  = 3'(i);
      end
    end
  end

  // Next-state logic: bus slave first, then the engine, then the interrupt status.
  always_comb begin
    q_nxt         = q_r;
    q_nxt.dack    = '0;
    ev            = '0;
    clr           = '0;
    blr_dec       = q_r.buffer_count[q_r.cur] - 16'h0001;

    // Two-cycle access: the answer is prepared in the first access cycle and the
    // write or read side effect lands on the edge that the master sees pready.
    if (acc && q_r.pready) begin
      q_nxt.pready  = 1'b0;
      q_nxt.pslverr = 1'b0;
      if (!q_r.pslverr && pwrite) begin
        // A write to the read-only status word is taken without error and changes nothing.
        if (glob) begin
          unique case (rsel)
            LLD_OFF_GCTL: q_nxt.spec = pwdata[LLD_GCTL_SPEC];
            LLD_OFF_IMSK: q_nxt.imsk = pwdata[LLD_NCH-1:0];
            default:      q_nxt.spec = q_r.spec;
          endcase
        end else begin
          unique case (rsel)
            LLD_OFF_LP: begin
              if (pstrb[0]) q_nxt.lp[rch][4:0]   = pwdata[7:3];
              if (pstrb[1]) q_nxt.lp[rch][12:5]  = pwdata[15:8];
              if (pstrb[2]) begin
                q_nxt.lp[rch][20:13] = pwdata[23:16];
                q_nxt.run[rch]       = 1'b1;
                q_nxt.hbuf[rch]      = 1'b0;
              end
            end
            LLD_OFF_BAR: q_nxt.bar[rch] = pwdata[LLD_BAR_W-1:0];
            LLD_OFF_BLR: q_nxt.buffer_count[rch] = pwdata[LLD_BLR_W-1:0];
            LLD_OFF_CCS: q_nxt.ctl[rch] = pwdata[2:0];
          endcase
        end
      end else if (!q_r.pslverr && glob && rsel == LLD_OFF_IST) begin
        clr = q_r.ist;
      end
    end else if (acc) begin
      q_nxt.pready  = 1'b1;
      q_nxt.pslverr = !hit;
      q_nxt.prdata  = hit ? rd : 32'h0000_0000;
    end

    // Shared engine.  Each memory request is held until it is acknowledged.
    unique case (q_r.st)
      LLD_IDLE: begin
        // A channel with no buffer loaded goes to fetch its next entry first.
        if (found) begin
          q_nxt.cur = pick;
          q_nxt.idx = 3'h0;
          q_nxt.st  = q_r.hbuf[pick] ? LLD_XFER : LLD_DESC;
        end
      end
      LLD_DESC: begin
        if (!q_r.mreq.req) begin
          q_nxt.mreq.req   = 1'b1;
          q_nxt.mreq.we    = 1'b0;
          q_nxt.mreq.addr  = {q_r.lp[q_r.cur], q_r.idx};
          q_nxt.mreq.wdata = 8'h00;
        end else if (mem_rsp.ack) begin
          q_nxt.mreq.req = 1'b0;
          q_nxt.idx      = q_r.idx + 3'h1;
          // Entry fields land in scratch first, so a link or end entry never disturbs
          // the buffer registers that software may be watching.
          // Byte +3 is read only to keep the walk through the entry in plain order.
          unique case (q_r.idx)
            3'h0: q_nxt.eaddr[7:0]   = mem_rsp.rdata;
            3'h1: q_nxt.eaddr[15:8]  = mem_rsp.rdata;
            3'h2: q_nxt.eaddr[23:16] = mem_rsp.rdata;
            3'h3: q_nxt.ltype        = q_r.ltype;
            3'h4: q_nxt.ltype        = mem_rsp.rdata;
            3'h5: q_nxt.elen         = mem_rsp.rdata;
            3'h6: q_nxt.ltype        = q_r.ltype;
            3'h7: q_nxt.ltype        = q_r.ltype;
          endcase
          if (q_r.idx == LLD_ENT_LEN1) begin
            q_nxt.idx = LLD_ENT_LEN0;
            if (q_r.ltype[LLD_TYPE_END]) begin
              q_nxt.run[q_r.cur] = 1'b0;
              ev[q_r.cur]        = q_r.ctl[q_r.cur][LLD_CCS_IE];
              q_nxt.st           = LLD_IDLE;
            end else if (q_r.ltype[LLD_TYPE_LINK]) begin
              q_nxt.lp[q_r.cur] = q_r.eaddr[23:3];
              q_nxt.st          = LLD_IDLE;
            end else begin
              // A buffer starts here, an empty one too: both registers take the entry.
              q_nxt.bar[q_r.cur] = q_r.eaddr;
              q_nxt.buffer_count[q_r.cur] = {mem_rsp.rdata, q_r.elen};
              if ({mem_rsp.rdata, q_r.elen} == 16'h0000) begin
                q_nxt.st = LLD_WBACK;
              end else begin
                q_nxt.hbuf[q_r.cur] = 1'b1;
                q_nxt.st            = LLD_XFER;
              end
            end
          end
        end
      end
      LLD_XFER: begin
        // Without burst the engine goes back to arbitration after each item; with burst
        // it stays on this channel for as long as the peripheral keeps asking.
        // One idle cycle after every acknowledge lets the peripheral drop its request.
        if (!q_r.mreq.req) begin
          if (dreq[q_r.cur] && !q_r.dack[q_r.cur]) begin
            q_nxt.mreq.req   = 1'b1;
            q_nxt.mreq.we    = q_r.ctl[q_r.cur][LLD_CCS_DIR];
            q_nxt.mreq.addr  = q_r.bar[q_r.cur];
            q_nxt.mreq.wdata = pdata_in;
          end else if (!q_r.dack[q_r.cur]) begin
            q_nxt.st = LLD_IDLE;
          end
        end else if (mem_rsp.ack) begin
          q_nxt.mreq.req      = 1'b0;
          q_nxt.dack[q_r.cur] = 1'b1;
          q_nxt.pdata         = q_r.mreq.we ? q_r.mreq.wdata : mem_rsp.rdata;
          q_nxt.bar[q_r.cur]  = q_r.bar[q_r.cur] + 24'h00_0001;
          q_nxt.buffer_count[q_r.cur]  = blr_dec;
          if (blr_dec == 16'h0000) begin
            q_nxt.hbuf[q_r.cur] = 1'b0;
            q_nxt.idx           = LLD_ENT_LEN0;
            q_nxt.st            = LLD_WBACK;
          end else if (!q_r.ctl[q_r.cur][LLD_CCS_BURST]) begin
            q_nxt.st = LLD_IDLE;
          end
        end
      end
      LLD_WBACK: begin
        // The final count goes back into the entry, low byte first; the list pointer
        // then steps on to the next eight-byte entry.
        if (!q_r.mreq.req) begin
          q_nxt.mreq.req   = 1'b1;
          q_nxt.mreq.we    = 1'b1;
          q_nxt.mreq.addr  = {q_r.lp[q_r.cur], q_r.idx};
          q_nxt.mreq.wdata = (q_r.idx == LLD_ENT_LEN0) ? q_r.buffer_count[q_r.cur][7:0]
                                                       : q_r.buffer_count[q_r.cur][15:8];
        end else if (mem_rsp.ack) begin
          q_nxt.mreq.req = 1'b0;
          q_nxt.idx      = LLD_ENT_LEN1;
          if (q_r.idx == LLD_ENT_LEN1) begin
            q_nxt.hbuf[q_r.cur] = 1'b0;
            q_nxt.lp[q_r.cur]   = q_r.lp[q_r.cur] + 21'h00_0001;
            q_nxt.st            = LLD_IDLE;
          end
        end
      end
    endcase

    // A new event wins over a clear made by the same read.
    // The interrupt is registered from the next status and mask, so it follows them
    // with no extra cycle of delay.
    q_nxt.ist = (q_r.ist & ~clr) | ev;
    q_nxt.irq = |(q_nxt.ist & q_nxt.imsk);
  end

  // Every channel owns private slices of the state; one register bank holds them all.
  // Reset stops every channel, clears the mask and leaves special access off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r    <= '0;
      q_r.st <= LLD_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign pready    = q_r.pready;
  assign prdata    = q_r.prdata;
  assign pslverr   = q_r.pslverr;
  assign mem_req   = q_r.mreq;
  assign dack      = q_r.dack;
  assign pdata_out = q_r.pdata;
  assign irq       = q_r.irq;

endmodule

/* lld_dma_chk.sv */
`timescale 1ns/1ps
// Port-level checks for the DMA block; every check is judged at the rising edge.
module lld_dma_chk import lld_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB slave.
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ADDR_W-1:0]           paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic                        pready,
  input wire logic [31:0]                 prdata,
  input wire logic                        pslverr,
  // Memory and peripheral side.
  input wire lld_pkg::lld_mem_req_t       mem_req,
  input wire lld_pkg::lld_mem_rsp_t       mem_rsp,
  input wire logic [lld_pkg::LLD_NCH-1:0] dreq,
  input wire logic [lld_pkg::LLD_NCH-1:0] dack,
  input wire logic [7:0]                  pdata_in,
  input wire logic [7:0]                  pdata_out,
  input wire logic                        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  // A completed bus access, the only cycle where answers count.
  assign acc = psel && penable && pready;
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after the wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_bad_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  chk_lp_low: assert property (acc && !pwrite && paddr[ADDR_W-1:7] == '0 && paddr[3:0] == 4'h0
    |-> prdata[2:0] == LLD_LP_LOW)
    else $error("list pointer low bits wrong");
  chk_req_hold: assert property (mem_req.req && !mem_rsp.ack
    |=> mem_req.req && $stable(mem_req.addr) && $stable(mem_req.we))
    else $error("memory request changed before ack");
  chk_req_gap: assert property (mem_req.req && mem_rsp.ack |=> !mem_req.req)
    else $error("memory request not released after ack");
  chk_dack_one: assert property ($onehot0(dack))
    else $error("more than one channel acknowledged");
  chk_dack_src: assert property (|dack |-> $past(mem_req.req && mem_rsp.ack))
    else $error("item acknowledged without memory ack");
  cov_write: cover property (acc && pwrite);
  cov_item: cover property (|dack);
  cov_irq: cover property (irq);
endmodule

/* lld_mem_model.sv */
`timescale 1ns/1ps
// Byte-wide system memory; answers each request after lat wait cycles.
module lld_mem_model (
  // Clock and reset.
  input wire logic                  pclk,
  input wire logic                  presetn,
  // Memory port.
  input wire lld_pkg::lld_mem_req_t req,
  output lld_pkg::lld_mem_rsp_t     rsp,
  // Wait cycles before each answer.
  input wire logic [3:0]            lat
);
  logic [7:0] mem [0:4095];
  logic [3:0] cnt;
  // Read data is scrambled outside the ack cycle so stale bytes are never trusted.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
      cnt <= 4'h0;
    end else if (rsp.ack) begin
      rsp <= {1'b0, ~rsp.rdata};
      cnt <= 4'h0;
    end else if (req.req && cnt >= lat) begin
      rsp.ack <= 1'b1;
      if (req.we) mem[req.addr[11:0]] <= req.wdata;
      else rsp.rdata <= mem[req.addr[11:0]];
    end else if (req.req) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

/* lld_pkg.sv */
package lld_pkg;

  // Channel count and register widths.
  localparam int LLD_NCH      = 8;
  localparam int LLD_LP_W     = 21;
  localparam int LLD_BAR_W    = 24;
  localparam int LLD_BLR_W    = 16;
  localparam int LLD_CCS_W    = 8;

  // Per-channel register word offsets inside a 16-byte channel slot.
  localparam logic [1:0] LLD_OFF_LP   = 2'h0;
  localparam logic [1:0] LLD_OFF_BAR  = 2'h1;
  localparam logic [1:0] LLD_OFF_BLR  = 2'h2;
  localparam logic [1:0] LLD_OFF_CCS  = 2'h3;

  // Shared registers, selected when address bit 7 is set.
  localparam logic [1:0] LLD_OFF_GCTL = 2'h0;
  localparam logic [1:0] LLD_OFF_IST  = 2'h1;
  localparam logic [1:0] LLD_OFF_IMSK = 2'h2;

  // Channel control/status fields.
  localparam int LLD_CCS_DIR   = 0;
  localparam int LLD_CCS_BURST = 1;
  localparam int LLD_CCS_IE    = 2;
  localparam int LLD_CCS_RUN   = 3;
  localparam int LLD_CCS_LOAD  = 4;
  localparam int LLD_CCS_END   = 5;
  localparam int LLD_GCTL_SPEC = 0;

  // Low bits of the list pointer as read back: the type/status byte.
  localparam logic [2:0] LLD_LP_LOW   = 3'h4;

  // List entry byte offsets and type codes.
  localparam logic [2:0] LLD_ENT_TYPE = 3'h4;
  localparam logic [2:0] LLD_ENT_LEN0 = 3'h5;
  localparam logic [2:0] LLD_ENT_LEN1 = 3'h6;
  localparam int LLD_TYPE_LINK = 0;
  localparam int LLD_TYPE_END  = 1;

  // Engine states, one-hot.
  typedef enum logic [3:0] {
    LLD_IDLE  = 4'b0001,
    LLD_DESC  = 4'b0010,
    LLD_XFER  = 4'b0100,
    LLD_WBACK = 4'b1000
  } lld_state_t;

  // Byte-wide system memory master port.
  typedef struct packed {
    logic                 req;
    logic                 we;
    logic [LLD_BAR_W-1:0] addr;
    logic [7:0]           wdata;
  } lld_mem_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } lld_mem_rsp_t;

endpackage
